// File: rtl/ssp_pkg.sv
// Purpose: shared constants and types of the synchronous serial port pin logic
// Assumes: frame length is carried as bit count minus one
// Notes: format codes are the values applied on the format select input
package ssp_pkg;

  // ----------------------------------------------------------------
  // bus formats
  // ----------------------------------------------------------------
  localparam logic [1:0] SSP_FMT_SPI = 2'h0;   // select-based, cpol/cpha programmable
  localparam logic [1:0] SSP_FMT_FRAME = 2'h1; // 4-wire frame-sync format
  localparam logic [1:0] SSP_FMT_CMD = 2'h2;   // select-based command format

  // ----------------------------------------------------------------
  // frame geometry and timing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] SSP_LEN_MIN = 4'h3;       // 4 bits, the shortest frame
  localparam logic [5:0] SSP_SYNC_HALVES = 6'h02;  // frame pulse lasts one clock period
  localparam logic [5:0] SSP_HALF_ONE = 6'h01;
  localparam logic [5:0] SSP_HALF_ZERO = 6'h00;
  localparam logic [1:0] SSP_TRAIL_LAST = 2'h2;    // last trail count, three link cycles held after the last bit
  localparam logic [1:0] SSP_TRAIL_ZERO = 2'h0;
  localparam logic [3:0] SSP_CNT_ZERO = 4'h0;
  localparam logic [1:0] SSP_PIPE_ZERO = 2'h0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SSP_WORD_RST = 16'h0000;

  // ----------------------------------------------------------------
  // master sequencer states, link domain
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_BITS, ST_TRAIL} ssp_state_t;

endpackage

// File: rtl/ssp_pin_if.sv
// Purpose: pin-level master/slave engine of a synchronous serial port
// Assumes: i_clk_link is a free running half-bit clock for master transfers
// Notes: master bits are paced on the link clock, slave pins are oversampled
//
// Functional notes
// - one master and one slave per transfer
// - frames of 4 to 16 bits, full duplex
// - SPI, frame-sync and command formats, master or slave
// - master drives serial clock, slave only receives it
// - SPI clock polarity programmable, others active high
// - clock toggles only during a transfer
// - master select spans the data bits
// - slave select input qualifies incoming data
// - slave drives, master samples slave-to-master line
// - master drives, slave samples master-to-slave line
// - unselected slave leaves its output undriven
// - frame master idles low, pulses sync one period
// - frame format: MSB first, out rising, sample falling
// - SPI phase picks first or second capture edge
`timescale 1ns/1ps
module ssp_pin_if
  import ssp_pkg::*;
(
  // clocks and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_clk_link,
  // configuration
  input wire logic i_enable,
  input wire logic i_master,
  input wire logic [1:0] i_format,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic [3:0] i_frame_len,
  // word stream
  input wire logic [15:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [15:0] o_rx_data,
  output logic o_rx_valid,
  output logic o_busy,
  // serial clock pin
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe,
  // select / frame sync pin
  input wire logic i_select_sync_pin,
  output logic o_select_sync_pin,
  output logic o_select_sync_pin_oe,
  // slave-to-master data pin
  input wire logic i_slave_to_master_pin,
  output logic o_slave_to_master_pin,
  output logic o_slave_to_master_pin_oe,
  // master-to-slave data pin
  input wire logic i_master_to_slave_pin,
  output logic o_master_to_slave_pin,
  output logic o_master_to_slave_pin_oe
);

  // ----------------------------------------------------------------
  // system domain: request side
  // ----------------------------------------------------------------
  logic as_master;
  logic s_run;
  logic accept;
  logic [3:0] len_eff;
  logic busy_reg, req_tg_reg;
  logic [1:0] cfg_fmt_reg;
  logic cfg_cpol_reg, cfg_cpha_reg;
  logic [3:0] cfg_len_reg;
  logic [15:0] cfg_word_reg;
  logic dn1_reg, dn2_reg, dn3_reg;
  logic m_done;
  // slave engine
  logic sk1_reg, sk2_reg, sk3_reg, ss1_reg, ss2_reg, sm1_reg, sm2_reg;
  logic [3:0] sl_cnt_reg;
  logic [15:0] sl_tx_reg, sl_rx_reg, sl_hold_reg;
  logic sl_hold_full_reg, sl_armed_reg;
  logic s_frm, s_pol, s_pha, s_edge, s_lead, s_trail;
  logic s_idle_sel, arm_evt, sel_active, s_cap, s_shift, s_done;
  // link domain
  logic lr1_reg, lr2_reg, rst_lk_n;
  logic rq1_reg, rq2_reg, rq_seen_reg, mi1_reg, mi2_reg;
  ssp_state_t st_lk;
  logic [5:0] h_lk, nh, nb, off, last_h;
  logic [1:0] t_lk, cap_pipe;
  logic [15:0] tx_lk, rx_lk, rxw_lk;
  logic sck_lk, sel_lk, mosi_oe_lk, dn_tg_lk;
  logic lk_act;
  logic frm, epol, epha, req_new, step, in_data, cap_now, shift_now;

  assign as_master = i_enable & i_master;
  assign s_run = i_enable & ~i_master;
  assign len_eff = (i_frame_len < SSP_LEN_MIN) ? SSP_LEN_MIN : i_frame_len;
  assign accept = i_tx_valid & o_tx_ready;
  assign m_done = dn2_reg ^ dn3_reg;

  // ready: master waits for its frame, slave for a free holding word
  assign o_tx_ready = i_enable & (i_master ? ~busy_reg : ~sl_hold_full_reg);
  assign o_busy = busy_reg | (s_run & sel_active);

  // latch one word with its configuration and raise a request toggle
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      req_tg_reg <= 1'b0;
      cfg_fmt_reg <= SSP_FMT_SPI;
      cfg_cpol_reg <= 1'b0;
      cfg_cpha_reg <= 1'b0;
      cfg_len_reg <= SSP_LEN_MIN;
      cfg_word_reg <= SSP_WORD_RST;
    end
    else if (accept && i_master)
    begin
      req_tg_reg <= ~req_tg_reg;
      cfg_fmt_reg <= i_format;
      cfg_cpol_reg <= i_cpol;
      cfg_cpha_reg <= i_cpha;
      cfg_len_reg <= len_eff;
      cfg_word_reg <= i_tx_data;
    end
  end

  // busy from acceptance until the link reports the frame done
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      busy_reg <= 1'b0;
    else if (accept && i_master)
      busy_reg <= 1'b1;
    else if (m_done)
      busy_reg <= 1'b0;
  end

  // done toggle back from the link, two stages then edge detect
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      dn1_reg <= 1'b0;
      dn2_reg <= 1'b0;
      dn3_reg <= 1'b0;
    end
    else
    begin
      dn1_reg <= dn_tg_lk;
      dn2_reg <= dn1_reg;
      dn3_reg <= dn2_reg;
    end
  end

  // ----------------------------------------------------------------
  // system domain: slave engine on oversampled pins
  // ----------------------------------------------------------------
  // pin synchronisers; sk3 only delays the second stage for edge detect
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      {sk1_reg, sk2_reg, sk3_reg} <= 3'h0;
      {ss1_reg, ss2_reg, sm1_reg, sm2_reg} <= 4'hF;
    end
    else
    begin
      sk1_reg <= i_serial_clock_pin;
      sk2_reg <= sk1_reg;
      sk3_reg <= sk2_reg;
      ss1_reg <= i_select_sync_pin;
      ss2_reg <= ss1_reg;
      sm1_reg <= i_master_to_slave_pin;
      sm2_reg <= sm1_reg;
    end
  end

  // effective polarity and phase per format
  assign s_frm = (i_format == SSP_FMT_FRAME);
  assign s_pol = (i_format == SSP_FMT_SPI) & i_cpol;
  assign s_pha = s_frm | ((i_format == SSP_FMT_SPI) & i_cpha);
  assign s_edge = sk2_reg ^ sk3_reg;
  assign s_lead = s_edge & (sk2_reg != s_pol);
  assign s_trail = s_edge & (sk2_reg == s_pol);
  // select qualifies data: low select, or armed by a sync pulse
  assign s_idle_sel = ~s_frm & ss2_reg;
  assign arm_evt = s_frm & s_trail & ss2_reg;
  assign sel_active = s_frm ? sl_armed_reg : ~ss2_reg;
  assign s_cap = sel_active & (s_pha ? s_trail : s_lead);
  assign s_shift = sel_active & (s_pha ? (s_lead & (sl_cnt_reg != SSP_CNT_ZERO)) : s_trail);
  assign s_done = s_run & ~s_idle_sel & ~arm_evt & s_cap & (sl_cnt_reg == len_eff);

  // slave shifter and holding word
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n || !s_run)
    begin
      sl_cnt_reg <= SSP_CNT_ZERO;
      sl_tx_reg <= SSP_WORD_RST;
      sl_rx_reg <= SSP_WORD_RST;
      sl_armed_reg <= 1'b0;
    end
    else if (s_idle_sel || arm_evt)
    begin
      sl_cnt_reg <= SSP_CNT_ZERO;
      sl_rx_reg <= SSP_WORD_RST;
      sl_tx_reg <= sl_hold_full_reg ? sl_hold_reg : SSP_WORD_RST;
      sl_armed_reg <= arm_evt;
    end
    else if (s_done)
    begin
      sl_cnt_reg <= SSP_CNT_ZERO;
      sl_rx_reg <= SSP_WORD_RST;
      sl_tx_reg <= SSP_WORD_RST;
      sl_armed_reg <= 1'b0;
    end
    else
    begin
      if (s_shift)
        sl_tx_reg <= {sl_tx_reg[14:0], 1'b0};
      if (s_cap)
      begin
        sl_rx_reg <= {sl_rx_reg[14:0], sm2_reg};
        sl_cnt_reg <= sl_cnt_reg + 4'h1;
      end
    end
  end

  // holding word: a new word wins over the clear at frame end
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      sl_hold_reg <= SSP_WORD_RST;
      sl_hold_full_reg <= 1'b0;
    end
    else if (accept && !i_master)
    begin
      sl_hold_reg <= i_tx_data;
      sl_hold_full_reg <= 1'b1;
    end
    else if (s_done || !s_run)
      sl_hold_full_reg <= 1'b0;
  end

  // received word from either engine, one-cycle valid
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_rx_data <= SSP_WORD_RST;
      o_rx_valid <= 1'b0;
    end
    else if (m_done)
    begin
      o_rx_data <= rxw_lk;
      o_rx_valid <= 1'b1;
    end
    else if (s_done)
    begin
      o_rx_data <= {sl_rx_reg[14:0], sm2_reg};
      o_rx_valid <= 1'b1;
    end
    else
      o_rx_valid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // link domain: master sequencer, one link cycle per half bit
  // ----------------------------------------------------------------
  // reset, request toggle and data input synchronisers
  always_ff @(posedge i_clk_link)
  begin
    lr1_reg <= i_rst_n;
    lr2_reg <= lr1_reg;
    if (!lr2_reg)
    begin
      {rq1_reg, rq2_reg, mi1_reg, mi2_reg} <= 4'h0;
    end
    else
    begin
      rq1_reg <= req_tg_reg;
      rq2_reg <= rq1_reg;
      mi1_reg <= i_slave_to_master_pin;
      mi2_reg <= mi1_reg;
    end
  end
  assign rst_lk_n = lr2_reg;

  // configuration is stable while a request is outstanding
  assign frm = (cfg_fmt_reg == SSP_FMT_FRAME);
  assign epol = (cfg_fmt_reg == SSP_FMT_SPI) & cfg_cpol_reg;
  assign epha = frm | ((cfg_fmt_reg == SSP_FMT_SPI) & cfg_cpha_reg);
  assign off = frm ? SSP_SYNC_HALVES : SSP_HALF_ZERO;
  assign last_h = {1'b0, cfg_len_reg, 1'b1} + off;
  assign req_new = (st_lk == ST_IDLE) & (rq2_reg != rq_seen_reg);
  assign step = (st_lk == ST_LEAD) | ((st_lk == ST_BITS) & (h_lk != last_h));
  assign nh = (st_lk == ST_BITS) ? h_lk + SSP_HALF_ONE : SSP_HALF_ZERO;
  assign nb = nh - off;
  assign in_data = ~(frm & (nh < SSP_SYNC_HALVES));
  assign cap_now = step & in_data & (epha ? nb[0] : ~nb[0]);
  assign shift_now = step & in_data & (epha ? (~nb[0] & (nb != SSP_HALF_ZERO)) : nb[0]);

  // sequencer: lead (select-based formats only), bit halves, trail, then report
  always_ff @(posedge i_clk_link)
  begin
    if (!rst_lk_n)
    begin
      st_lk <= ST_IDLE;
      h_lk <= SSP_HALF_ZERO;
      t_lk <= SSP_TRAIL_ZERO;
      tx_lk <= SSP_WORD_RST;
      rxw_lk <= SSP_WORD_RST;
      sck_lk <= 1'b0;
      sel_lk <= 1'b1;
      mosi_oe_lk <= 1'b0;
      dn_tg_lk <= 1'b0;
      rq_seen_reg <= 1'b0;
    end
    else
    begin
      case (st_lk)
        ST_IDLE:
        begin
          if (req_new)
          begin
            rq_seen_reg <= rq2_reg;
            tx_lk <= cfg_word_reg;
            h_lk <= SSP_HALF_ZERO;
            if (frm)
            begin
              st_lk <= ST_BITS;
              sck_lk <= 1'b1;
              sel_lk <= 1'b1;
            end
            else
            begin
              st_lk <= ST_LEAD;
              sck_lk <= epol;
              sel_lk <= 1'b0;
              mosi_oe_lk <= 1'b1;
            end
          end
          else
            sel_lk <= ~frm;
        end
        ST_LEAD, ST_BITS:
        begin
          if (step)
          begin
            st_lk <= ST_BITS;
            h_lk <= nh;
            sck_lk <= epol ^ ~nh[0];
            if (frm)
              sel_lk <= (nh < SSP_SYNC_HALVES);
            if (frm && nh == SSP_SYNC_HALVES)
              mosi_oe_lk <= 1'b1;
            if (shift_now)
              tx_lk <= {tx_lk[14:0], 1'b0};
          end
          else
          begin
            st_lk <= ST_TRAIL;
            t_lk <= SSP_TRAIL_ZERO;
            sck_lk <= epol;
          end
        end
        ST_TRAIL:
        begin
          t_lk <= t_lk + 2'h1;
          if (t_lk == SSP_TRAIL_LAST)
          begin
            st_lk <= ST_IDLE;
            sel_lk <= ~frm;
            mosi_oe_lk <= 1'b0;
            rxw_lk <= rx_lk;
            dn_tg_lk <= ~dn_tg_lk;
          end
        end
        default:
        begin
          st_lk <= ST_IDLE;
        end
      endcase
    end
  end

  // capture runs two link cycles behind the edge to cover the synchroniser
  always_ff @(posedge i_clk_link)
  begin
    if (!rst_lk_n)
    begin
      cap_pipe <= SSP_PIPE_ZERO;
      rx_lk <= SSP_WORD_RST;
    end
    else
    begin
      cap_pipe <= {cap_pipe[0], cap_now};
      if (req_new)
        rx_lk <= SSP_WORD_RST;
      else if (cap_pipe[1])
        rx_lk <= {rx_lk[14:0], mi2_reg};
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // clock and select driven only as enabled master; slave only listens
  // link levels shown only once the link has taken the request, so no stale edge leaks out
  assign lk_act = busy_reg & (st_lk != ST_IDLE);
  assign o_serial_clock_pin = lk_act ? sck_lk : ((i_format == SSP_FMT_SPI) & i_cpol);
  assign o_serial_clock_pin_oe = as_master;
  assign o_select_sync_pin = lk_act ? sel_lk : (i_format != SSP_FMT_FRAME);
  assign o_select_sync_pin_oe = as_master;
  assign o_master_to_slave_pin = tx_lk[cfg_len_reg];
  assign o_master_to_slave_pin_oe = as_master & busy_reg & mosi_oe_lk;
  assign o_slave_to_master_pin = sl_tx_reg[len_eff];
  assign o_slave_to_master_pin_oe = s_run & sel_active;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_spi_lead;
    st_lk == ST_LEAD && cfg_fmt_reg == SSP_FMT_SPI;
  endsequence
  sequence seq_fs_pulse;
    sel_lk [*2] ##1 !sel_lk;
  endsequence
  sequence seq_trail;
    (st_lk == ST_TRAIL) [*2] ##1 (st_lk == ST_IDLE && sel_lk == !frm);
  endsequence

  AST_FS_PULSE: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    (frm && $rose(sel_lk)) |-> seq_fs_pulse)
    else $error("frame pulse not one clock period");
  AST_SPI_LEAD: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    seq_spi_lead |-> (!sel_lk && sck_lk == epol) ##1 (!sel_lk && sck_lk != epol))
    else $error("select not ahead of first clock edge");
  AST_TRAIL: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    ($past(st_lk) == ST_BITS && st_lk == ST_TRAIL) |-> ##1 seq_trail)
    else $error("select released at wrong time");
  AST_BIT_COUNT: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    ($past(st_lk) == ST_BITS && st_lk == ST_TRAIL) |-> $past(h_lk) == last_h)
    else $error("wrong number of clock halves");
  AST_SCK_STILL: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    (st_lk == ST_IDLE && $past(st_lk) == ST_IDLE) |-> $stable(sck_lk))
    else $error("clock moved while idle");
  AST_ACTIVE_HIGH: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    (cfg_fmt_reg != SSP_FMT_SPI && st_lk == ST_TRAIL) |-> !sck_lk)
    else $error("non-SPI clock idle level not low");
  AST_DX_TRISTATE: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    (frm && st_lk == ST_BITS && h_lk < SSP_SYNC_HALVES) |-> !mosi_oe_lk)
    else $error("transmit line driven during sync");
  AST_MOSI_IDLE: assert property (@(posedge i_clk_link) disable iff (!rst_lk_n)
    mosi_oe_lk |-> st_lk != ST_IDLE)
    else $error("data line driven while idle");
  AST_DONE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    m_done |=> (!busy_reg && o_rx_valid && o_rx_data == $past(rxw_lk)))
    else $error("finished frame not reported");
  AST_S2M_HIZ: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (s_run && !s_frm && $past(ss2_reg) && ss2_reg) |-> !o_slave_to_master_pin_oe)
    else $error("unselected slave drives its output");
  AST_SLAVE_NO_SCK: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !as_master |-> (!o_serial_clock_pin_oe && !o_master_to_slave_pin_oe))
    else $error("non-master drives clock or data");
  AST_ONE_DRIVER: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !(o_slave_to_master_pin_oe && o_master_to_slave_pin_oe))
    else $error("both data directions driven");

endmodule

// File: sim/ssp_far_end.sv
// Purpose: far-end serial device, slave while the port masters, master otherwise
// Assumes: its configuration inputs match the port under test
// Notes: behavioural and event driven; master role paces 62.5 ns half periods
`timescale 1ns/1ps
module ssp_far_end
  import ssp_pkg::*;
(
  // role and configuration
  input wire logic i_dut_master,
  input wire logic [1:0] i_format,
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic [3:0] i_len,
  input wire logic [15:0] i_word,
  // resolved pins
  input wire logic i_sck,
  input wire logic i_sel,
  input wire logic i_mosi,
  input wire logic i_miso,
  // driven pins
  output logic o_sck,
  output logic o_sel,
  output logic o_mosi,
  output logic o_mosi_oe,
  output logic o_miso,
  output logic o_miso_oe,
  // word received in slave role
  output logic [15:0] o_rx
);
  // ----------------------------------------
  // slave role
  // ----------------------------------------
  logic act = 1'b0;
  int idx = 0;
  int caps = 0;
  logic cap_lvl;
  logic late;
  // clock level after a capture edge, and whether a shift edge leads
  assign cap_lvl = (i_format == SSP_FMT_FRAME) ? 1'b0 :
    ((i_format == SSP_FMT_SPI) ? (i_cpol == i_cpha) : 1'b1);
  assign late = (i_format == SSP_FMT_FRAME) || (i_format == SSP_FMT_SPI && i_cpha);
  // output only while selected; out of range bits show a moving level
  assign o_miso_oe = act && i_dut_master;
  assign o_miso = (idx >= 0 && idx <= int'(i_len)) ? i_word[int'(i_len) - idx] : ~i_sck;
  // select opens and closes a frame in select-based formats
  always @(i_sel)
  begin
    if (i_dut_master && i_format != SSP_FMT_FRAME)
    begin
      act = !i_sel;
      idx = late ? -1 : 0;
      caps = 0;
    end
  end
  // sync seen on a falling edge arms; then shift on one edge, capture on the other
  always @(i_sck)
  begin
    if (i_dut_master && i_format == SSP_FMT_FRAME && !i_sck && i_sel)
    begin
      act = 1'b1;
      idx = -1;
      caps = 0;
    end
    else if (act && i_dut_master)
    begin
      if (i_sck == cap_lvl)
      begin
        o_rx = {o_rx[14:0], i_mosi};
        caps++;
      end
      else
        idx++;
    end
  end
  // master role: clock and select held idle outside frames
  initial
  begin
    o_sck = 1'b0;
    o_sel = 1'b1;
    o_mosi = 1'b0;
    o_mosi_oe = 1'b0;
  end
  // one mode 0 frame, msb first, capture on the rising edge
  task automatic send(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    o_sel = 1'b0;
    o_mosi_oe = 1'b1;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_mosi = w[i];
      #62.5 o_sck = 1'b1;
      r = {r[14:0], i_miso};
      #62.5 o_sck = 1'b0;
    end
    #125 o_sel = 1'b1;
    o_mosi_oe = 1'b0;
  endtask
endmodule

// File: sim/ssp_pin_if_tb.sv
// Purpose: self-checking bench of the serial port pin engine
// Assumes: far end modelled by ssp_far_end, one master and one slave
// Notes: link clock 125 ns, free running and out of phase with the system clock
`timescale 1ns/1ps
module ssp_pin_if_tb
  import ssp_pkg::*;
;
  // ----------------------------------------
  // stimulus, pins and monitors
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  logic master = 1'b0;
  logic [1:0] fmt = SSP_FMT_SPI;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic [3:0] len = 4'h7;
  logic [15:0] tx_data = 16'h0000;
  logic tx_valid = 1'b0;
  logic [15:0] far_word = 16'h0000;
  logic junk = 1'b0;
  logic tx_ready, rx_valid, busy;
  logic [15:0] rx_data, far_rx, r16;
  logic d_sck, d_sck_oe, d_sel, d_sel_oe, d_miso, d_miso_oe, d_mosi, d_mosi_oe;
  logic f_sck, f_sel, f_mosi, f_mosi_oe, f_miso, f_miso_oe;
  logic sck_w, sel_w, miso_w, mosi_w;
  logic [15:0] rx_last = 16'h0000;
  int bad_count = 0;
  int samples_checked = 0;
  int rx_seen = 0;
  int edges = 0;
  int stray = 0;
  realtime t_up = 0.0;
  realtime t_dn = 0.0;
  // clocks
  always #2.5 clk_sys = ~clk_sys;
  initial
  begin
    #1.1;
    forever #62.5 clk_link = ~clk_link;
  end
  always #3.3 junk = ~junk;
  // wires: whoever enables drives, released data lines show a moving level
  assign sck_w = d_sck_oe ? d_sck : f_sck;
  assign sel_w = d_sel_oe ? d_sel : f_sel;
  assign miso_w = d_miso_oe ? d_miso : (f_miso_oe ? f_miso : junk);
  assign mosi_w = d_mosi_oe ? d_mosi : (f_mosi_oe ? f_mosi : junk);
  ssp_pin_if u_dut (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_clk_link(clk_link), .i_enable(enable),
    .i_master(master), .i_format(fmt), .i_cpol(cpol), .i_cpha(cpha), .i_frame_len(len),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .o_busy(busy), .i_serial_clock_pin(sck_w),
    .o_serial_clock_pin(d_sck), .o_serial_clock_pin_oe(d_sck_oe), .i_select_sync_pin(sel_w),
    .o_select_sync_pin(d_sel), .o_select_sync_pin_oe(d_sel_oe),
    .i_slave_to_master_pin(miso_w), .o_slave_to_master_pin(d_miso),
    .o_slave_to_master_pin_oe(d_miso_oe), .i_master_to_slave_pin(mosi_w),
    .o_master_to_slave_pin(d_mosi), .o_master_to_slave_pin_oe(d_mosi_oe));
  ssp_far_end u_far (
    .i_dut_master(master), .i_format(fmt), .i_cpol(cpol), .i_cpha(cpha), .i_len(len),
    .i_word(far_word), .i_sck(sck_w), .i_sel(sel_w), .i_mosi(mosi_w), .i_miso(miso_w),
    .o_sck(f_sck), .o_sel(f_sel), .o_mosi(f_mosi), .o_mosi_oe(f_mosi_oe), .o_miso(f_miso),
    .o_miso_oe(f_miso_oe), .o_rx(far_rx));
  // received frames, clock edges and sync pulse timing
  always @(posedge clk_sys)
  begin
    if (rx_valid === 1'b1)
    begin
      rx_seen <= rx_seen + 1;
      rx_last <= rx_data;
    end
  end
  always @(sck_w)
  begin
    edges++;
    if (sel_w === 1'b1 && fmt != SSP_FMT_FRAME)
      stray++;
  end
  always @(posedge sel_w) t_up = $realtime;
  always @(negedge sel_w) t_dn = $realtime;
  // ----------------------------------------
  // shared tasks and scenarios
  // ----------------------------------------
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic setup(input logic e, input logic m, input logic [1:0] f, input logic p,
                       input logic h, input logic [3:0] l);
    @(posedge clk_sys);
    enable <= e;
    master <= m;
    fmt <= f;
    cpol <= p;
    cpha <= h;
    len <= l;
    repeat (120) @(posedge clk_sys);
    edges = 0;
    stray = 0;
  endtask
  task automatic push(input logic [15:0] w);
    int n;
    n = 0;
    @(posedge clk_sys);
    tx_data <= w;
    tx_valid <= 1'b1;
    do @(posedge clk_sys); while (tx_ready !== 1'b1 && ++n < 400);
    tx_valid <= 1'b0;
  endtask
  task automatic wait_rx(input int was);
    int n;
    n = 0;
    while (rx_seen == was && n < 4000)
    begin
      @(posedge clk_sys);
      n++;
    end
    check16("frame done", 16'h0001, 16'(rx_seen - was));
  endtask
  task automatic t_idle();
    check16("pins after reset", 16'h0000, {12'h000, d_sck_oe, d_sel_oe, d_miso_oe, d_mosi_oe});
    setup(1'b1, 1'b1, SSP_FMT_SPI, 1'b1, 1'b0, 4'h7);
    check16("master idle", 16'h000E, {12'h000, d_sck_oe, d_sck, d_sel, d_mosi_oe});
  endtask
  task automatic t_master(input logic [1:0] f, input logic p, input logic h,
                          input logic [3:0] l, input logic [15:0] w);
    logic [15:0] m;
    int was;
    m = 16'hFFFF >> (4'hF - l);
    far_word = ~w;
    setup(1'b1, 1'b1, f, p, h, l);
    was = rx_seen;
    push(w);
    @(negedge clk_sys) check16("busy in frame", 16'h0001, {15'h0000, busy});
    wait_rx(was);
    check16("busy after frame", 16'h0000, {15'h0000, busy});
    check16("master rx", ~w & m, rx_last);
    check16("far rx", w & m, far_rx & m);
    check16("clock edges", 16'(2 * (l + 1) + (f == SSP_FMT_FRAME ? 2 : 0)), 16'(edges));
    check16("stray edges", 16'h0000, 16'(stray));
    check16("idle clock", {15'h0000, f == SSP_FMT_SPI && p}, {15'h0000, sck_w});
    check16("idle select", {15'h0000, f != SSP_FMT_FRAME}, {15'h0000, sel_w});
    check16("idle data out", 16'h0000, {15'h0000, d_mosi_oe});
    if (f == SSP_FMT_FRAME)
      check16("sync width", 16'h00FA, 16'(int'(t_dn - t_up)));
  endtask
  task automatic t_slave(input logic [1:0] f, input logic e, input logic [15:0] w);
    int was;
    setup(e, 1'b0, f, 1'b0, 1'b0, 4'h7);
    if (e)
      push(~w);
    was = rx_seen;
    check16("slave pins", 16'h0000, {14'h0000, d_sck_oe, d_miso_oe});
    u_far.send(w, 8, r16);
    repeat (20) @(posedge clk_sys);
    check16("slave frames", {15'h0000, e}, 16'(rx_seen - was));
    if (e)
      check16("slave rx", w & 16'h00FF, rx_last);
    if (e)
      check16("far rx", ~w & 16'h00FF, r16);
    check16("released out", 16'h0000, {15'h0000, d_miso_oe});
  endtask
  // main sequence
  initial
  begin
    repeat (100) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_idle();
    for (int i = 0; i < 4; i++)
      t_master(SSP_FMT_SPI, i[1], i[0], 4'(3 + 4 * i), 16'hC3A5 ^ 16'(i));
    t_master(SSP_FMT_FRAME, 1'b0, 1'b0, 4'h7, 16'h5A3C);
    t_master(SSP_FMT_CMD, 1'b0, 1'b0, 4'hB, 16'h0E71);
    t_slave(SSP_FMT_SPI, 1'b1, 16'h9C36);
    t_slave(SSP_FMT_CMD, 1'b1, 16'h0B4D);
    t_slave(SSP_FMT_SPI, 1'b0, 16'h7E11);
    close_out();
  end
  // watchdog
  initial
  begin
    #400000;
    bad_count++;
    $display("wrong value watchdog expected done seen hang");
    close_out();
  end
endmodule
